/* File: hdl/twowire_defs.svh */
// Offsets, field positions and reset values of the two-wire port.
// Assumes inclusion by the package and the bench; the guard keeps it once per compile.
`ifndef TWOWIRE_DEFS_SVH
`define TWOWIRE_DEFS_SVH
`define DATA_INDEX        8'h9B
`define DATA_ADDR         12'h26C
`define CTRL_ADDR         12'h000
`define STAT_ADDR         12'h004
`define CTRL_COUNT_WIDTH_SELECT_BIT   0
`define CTRL_EN_BIT       1
`define STAT_CNT_BIT      0
`define STAT_COND_BIT     1
`define STAT_STRETCH_BIT  2
`define STAT_START_BIT    3
`define STAT_STOP_BIT     4
`define STAT_COUNT_LSB    8
`define DATA_RESET        8'hFF
`define CTRL_RESET        2'h2
`define FULL_COUNT        4'h8
`define ONE_COUNT         4'h1
`endif

/* File: hdl/twowire_pkg.sv */
// Types shared by the two-wire port.
// Assumes the defines header sits beside this file.
package twowire_pkg;
`include "twowire_defs.svh"
	typedef enum logic [1:0]
	{
		BUS_IDLE,
		BUS_READ,
		BUS_WRITE
	} bus_phase_e;
	typedef logic [7:0] byte_t;
endpackage

/* File: hdl/software_assisted_twowire_port.sv */
// Software-assisted two-wire serial port with an AHB-Lite register slave.
// Assumes SDA is formed outside by joining the input and open-drain output.
// Operation
// R1 - Bit counter: SCL fall counts, access/condition clears
// R2 - START or STOP raises condition interrupt
// R3 - Count interrupt when counter reaches eight
// R4 - Select makes count interrupt fire per bit; code fires only at the first SCL fall after a clear
// R5 - Hold SCL low after eighth bit
// R6 - One-bit interrupt after acknowledge latched
// R7 - Data register access clears count interrupt
// R8 - Unread byte lost when next transfer starts
// R9 - Sample SDA into buffer on SCL rise
// R10 - Master transmit: software writes FF for acknowledge
// R11 - Software acknowledges with 7F, not-acknowledge FF
// R12 - Software makes START and STOP in master
// R13 - Software changes SDA only while SCL low
// R14 - Software does address, direction, acknowledge in slave
// R15 - Slave transmit shifts written byte per SCL
// R16 - After slave byte, flag and stretch until write
// R17 - Slave receive: FF first, flag and stretch
// R18 - Data write clears interrupt, releases stretch
// R19 - Board joins serial pins to form SDA
// R20 - Master SCL from source select or software; code has no source select and drives SCL low only for the stretch
// R21 - Reset clears counter, interrupts and stretch
`timescale 1ns/1ps
module software_assisted_twowire_port
	import twowire_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	output logic             bit_count_irq,
	output logic             bus_condition_irq
);

	bus_phase_e  phase_ff;
	logic [11:0] addr_ff;
	logic [1:0]  twowire_control_ff;
	byte_t       shift_ff;
	logic [3:0]  count_ff;
	logic        cnt_flag_ff;
	logic        cond_flag_ff;
	logic        stretch_ff;
	logic        start_seen_ff;
	logic        stop_seen_ff;
	logic [1:0]  scl_sync_ff;
	logic [1:0]  sda_sync_ff;
	logic        scl_prev_ff;
	logic        sda_prev_ff;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_det;
	logic        stop_det;
	logic        data_rd;
	logic        data_wr;
	logic        data_access;
	logic        count_hit;
	logic        enable;
	logic [3:0]  target;
	logic [31:0] rd_mux;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign enable    = twowire_control_ff[`CTRL_EN_BIT];

	// Address phase capture
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			phase_ff <= BUS_IDLE;
			addr_ff  <= 12'h000;
		end
		else if (hready)
		begin
			if (hsel && htrans[1])
			begin
				phase_ff <= hwrite ? BUS_WRITE : BUS_READ;
				addr_ff  <= haddr[11:0];
			end
			else
				phase_ff <= BUS_IDLE;
		end
	end

	assign data_rd     = (phase_ff == BUS_READ) && (addr_ff == `DATA_ADDR);
	assign data_wr     = (phase_ff == BUS_WRITE) && (addr_ff == `DATA_ADDR);
	assign data_access = data_rd || data_wr;

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		case (haddr[11:0])
			`DATA_ADDR: rd_mux[7:0] = shift_ff;
			`CTRL_ADDR: rd_mux[1:0] = twowire_control_ff;
			`STAT_ADDR:
			begin
				rd_mux[`STAT_CNT_BIT]     = cnt_flag_ff;
				rd_mux[`STAT_COND_BIT]    = cond_flag_ff;
				rd_mux[`STAT_STRETCH_BIT] = stretch_ff;
				rd_mux[`STAT_START_BIT]   = start_seen_ff;
				rd_mux[`STAT_STOP_BIT]    = stop_seen_ff;
				rd_mux[`STAT_COUNT_LSB+3:`STAT_COUNT_LSB] = count_ff;
			end
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data captured with the address phase, stands through the data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (hready && hsel && htrans[1] && !hwrite)
			hrdata <= rd_mux;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			twowire_control_ff <= `CTRL_RESET;
		else if ((phase_ff == BUS_WRITE) && (addr_ff == `CTRL_ADDR))
			twowire_control_ff <= hwdata[1:0];
	end

	// Pin synchronisers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			scl_sync_ff <= 2'h3;
			sda_sync_ff <= 2'h3;
			scl_prev_ff <= 1'b1;
			sda_prev_ff <= 1'b1;
		end
		else
		begin
			scl_sync_ff <= {scl_sync_ff[0], scl_in};
			sda_sync_ff <= {sda_sync_ff[0], sda_in};
			scl_prev_ff <= scl_sync_ff[1];
			sda_prev_ff <= sda_sync_ff[1];
		end
	end

	assign scl_rise  = enable && scl_sync_ff[1] && !scl_prev_ff;
	assign scl_fall  = enable && !scl_sync_ff[1] && scl_prev_ff;
	assign start_det = enable && scl_sync_ff[1] && scl_prev_ff && sda_prev_ff && !sda_sync_ff[1];
	assign stop_det  = enable && scl_sync_ff[1] && scl_prev_ff && !sda_prev_ff && sda_sync_ff[1];

	assign target    = twowire_control_ff[`CTRL_COUNT_WIDTH_SELECT_BIT] ? `ONE_COUNT : `FULL_COUNT; // see R4
	assign count_hit = scl_fall && ((count_ff + 4'h1) == target);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			count_ff <= 4'h0; // see R21
		else if (data_access || start_det || stop_det)
			count_ff <= 4'h0; // see R1
		else if (scl_fall && count_ff != 4'hF)
			count_ff <= count_ff + 4'h1; // see R1
	end

	// Shift register: sample on rise, present next bit after fall
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			shift_ff <= `DATA_RESET;
		else if (data_wr)
			shift_ff <= hwdata[7:0];
		else if (scl_rise)
			shift_ff <= {shift_ff[6:0], sda_sync_ff[1]}; // see R9
	end

	// MSB drives open-drain SDA, so the byte shifts out by master SCL
	assign sda_out = 1'b0;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			sda_oe <= 1'b0;
		else if (!enable)
			sda_oe <= 1'b0;
		else if (data_wr)
			sda_oe <= !hwdata[7]; // see R15
		else if (scl_fall)
			sda_oe <= !shift_ff[7]; // see R15
	end

	// Count flag: set beats clear; a new byte's first bit drops an unread flag
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cnt_flag_ff <= 1'b0; // see R21
		else if (count_hit)
			cnt_flag_ff <= 1'b1; // see R3 R6
		else if (data_access)
			cnt_flag_ff <= 1'b0; // see R7 R18
		else if (scl_fall && cnt_flag_ff)
			cnt_flag_ff <= 1'b0; // see R8
	end

	// Stretch after a full byte until software writes data
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			stretch_ff <= 1'b0; // see R21
		else if (count_hit && target == `FULL_COUNT)
			stretch_ff <= 1'b1; // see R5 R16 R17
		else if (data_wr)
			stretch_ff <= 1'b0; // see R18
	end

	assign scl_out = 1'b0;
	assign scl_oe  = stretch_ff;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cond_flag_ff  <= 1'b0; // see R21
			start_seen_ff <= 1'b0;
			stop_seen_ff  <= 1'b0;
		end
		else if (start_det || stop_det)
		begin
			cond_flag_ff  <= 1'b1; // see R2
			start_seen_ff <= start_det;
			stop_seen_ff  <= stop_det;
		end
		// Clear only a condition that the status read reported
		else if ((phase_ff == BUS_READ) && (addr_ff == `STAT_ADDR) && hrdata[`STAT_COND_BIT])
			cond_flag_ff  <= 1'b0;
	end

	assign bit_count_irq     = cnt_flag_ff; // see R3
	assign bus_condition_irq = cond_flag_ff; // see R2

	property p_count_clear;
		@(posedge hclk) disable iff (!hresetn)
		(data_access && !start_det) |=> (count_ff == 4'h0);
	endproperty
	a_count_clear: assert property (p_count_clear) else $error("counter not cleared"); // see R1

	property p_count_step;
		@(posedge hclk) disable iff (!hresetn)
		(scl_fall && !data_access && !start_det && !stop_det && count_ff < 4'h7)
			|=> (count_ff == $past(count_ff) + 4'h1);
	endproperty
	a_count_step: assert property (p_count_step) else $error("counter missed fall"); // see R1

	property p_cond;
		@(posedge hclk) disable iff (!hresetn)
		(start_det || stop_det) |=> bus_condition_irq;
	endproperty
	a_cond: assert property (p_cond) else $error("condition irq missing"); // see R2

	property p_eight;
		@(posedge hclk) disable iff (!hresetn)
		(scl_fall && count_ff == 4'h7 && !twowire_control_ff[0] && !data_access && !start_det && !stop_det)
			|=> bit_count_irq && scl_oe;
	endproperty
	a_eight: assert property (p_eight) else $error("no irq or stretch at eight"); // see R3

	property p_one;
		@(posedge hclk) disable iff (!hresetn)
		(scl_fall && count_ff == 4'h0 && twowire_control_ff[0] && !data_access && !start_det && !stop_det)
			|=> bit_count_irq;
	endproperty
	a_one: assert property (p_one) else $error("no one-bit irq"); // see R4

	property p_hold;
		@(posedge hclk) disable iff (!hresetn)
		(scl_oe && !data_wr) |=> scl_oe;
	endproperty
	a_hold: assert property (p_hold) else $error("stretch released early"); // see R5

	property p_wr_release;
		@(posedge hclk) disable iff (!hresetn)
		(data_wr && !count_hit) |=> (!scl_oe && !bit_count_irq);
	endproperty
	a_wr_release: assert property (p_wr_release) else $error("write did not release"); // see R18

	property p_rd_clear;
		@(posedge hclk) disable iff (!hresetn)
		(data_rd && !count_hit) |=> !bit_count_irq;
	endproperty
	a_rd_clear: assert property (p_rd_clear) else $error("read did not clear"); // see R7

	property p_lost;
		@(posedge hclk) disable iff (!hresetn)
		(bit_count_irq && scl_fall && !count_hit) |=> !bit_count_irq;
	endproperty
	a_lost: assert property (p_lost) else $error("stale irq kept"); // see R8

	property p_sample;
		@(posedge hclk) disable iff (!hresetn)
		(scl_rise && !data_wr) |=> (shift_ff[0] == $past(sda_sync_ff[1]));
	endproperty
	a_sample: assert property (p_sample) else $error("bit not sampled"); // see R9

	property p_rd_data;
		@(posedge hclk) disable iff (!hresetn)
		(hready && hsel && htrans[1] && !hwrite && (haddr[11:0] == `DATA_ADDR)) |=> (hrdata[7:0] == $past(shift_ff));
	endproperty
	a_rd_data: assert property (p_rd_data) else $error("read data not the shift byte"); // see R9

	property p_one_no_stretch;
		@(posedge hclk) disable iff (!hresetn)
		(count_hit && twowire_control_ff[`CTRL_COUNT_WIDTH_SELECT_BIT] && !scl_oe) |=> !scl_oe;
	endproperty
	a_one_no_stretch: assert property (p_one_no_stretch) else $error("stretch in one-bit mode"); // see R4

	property p_cond_clear;
		@(posedge hclk) disable iff (!hresetn)
		((phase_ff == BUS_READ) && (addr_ff == `STAT_ADDR) && hrdata[`STAT_COND_BIT] && !start_det && !stop_det)
			|=> !bus_condition_irq;
	endproperty
	a_cond_clear: assert property (p_cond_clear) else $error("condition irq kept after read"); // see R2

	property p_sda_drive;
		@(posedge hclk) disable iff (!hresetn)
		(data_wr && enable) |=> (sda_oe == !$past(hwdata[7]));
	endproperty
	a_sda_drive: assert property (p_sda_drive) else $error("first bit not driven"); // see R15

	property p_quiet;
		@(posedge hclk) disable iff (!hresetn)
		(!enable) |=> !sda_oe;
	endproperty
	a_quiet: assert property (p_quiet) else $error("data line driven while disabled");

	c_byte: cover property (@(posedge hclk) disable iff (!hresetn) count_hit && !twowire_control_ff[0]);
	c_lost: cover property (@(posedge hclk) disable iff (!hresetn) bit_count_irq && scl_fall && !count_hit);
	c_ack: cover property (@(posedge hclk) disable iff (!hresetn) count_hit && twowire_control_ff[0]);
	c_start: cover property (@(posedge hclk) disable iff (!hresetn) start_det);
	c_release: cover property (@(posedge hclk) disable iff (!hresetn) scl_oe ##1 !scl_oe);

endmodule

/* File: testbench/twowire_bus_master.sv */
// Model of the other master on the two-wire bus, toggling SCL and SDA in software.
// Assumes the bench forms both lines with pull-ups from all pull enables.
`timescale 1ns/1ps
module twowire_bus_master
(
	input  wire logic hclk,
	input  wire logic scl_line,
	input  wire logic sda_line,
	output logic      scl_pull,
	output logic      sda_pull
);
	localparam int HALF = 20;
	initial
	begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task automatic start_cond();
		sda_pull <= 1'b1;
		tick(HALF);
		scl_pull <= 1'b1;
		tick(HALF);
	endtask
	task automatic stop_cond();
		sda_pull <= 1'b1;
		tick(HALF);
		scl_pull <= 1'b0;
		tick(HALF);
		sda_pull <= 1'b0;
		tick(HALF);
	endtask
	// One bit; a stretched clock is waited out, bounded
	task automatic clock_bit(input logic b, output logic s);
		sda_pull <= ~b;
		tick(HALF);
		scl_pull <= 1'b0;
		for (int n = 0; n < 2000 && scl_line !== 1'b1; n++) @(posedge hclk);
		tick(HALF);
		s = sda_line;
		scl_pull <= 1'b1;
		tick(HALF);
	endtask
	task automatic byte_xfer(input logic [7:0] v, output logic [7:0] r);
		for (int i = 7; i >= 0; i--)
			clock_bit(v[i], r[i]);
	endtask
endmodule

/* File: testbench/software_assisted_twowire_port_tb_top.sv */
// Bench for the two-wire port: AHB-Lite register tasks plus a bus master model.
// Assumes the package and its defines header are compiled first.
`timescale 1ns/1ps
`include "twowire_defs.svh"
module software_assisted_twowire_port_tb_top;
	import twowire_pkg::*;
	localparam logic [31:0] CNT = 32'h1 << `STAT_CNT_BIT;
	localparam logic [31:0] CND = 32'h1 << `STAT_COND_BIT;
	localparam logic [31:0] STR = 32'h1 << `STAT_STRETCH_BIT;
	localparam logic [31:0] STA = 32'h1 << `STAT_START_BIT;
	localparam logic [31:0] STO = 32'h1 << `STAT_STOP_BIT;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        scl_out, scl_oe, sda_out, sda_oe, scl_pull, sda_pull, b;
	logic        bit_count_irq, bus_condition_irq;
	wire         scl_line;
	wire         sda_line;
	logic [7:0]  r;
	int          fails;
	int          n_tests;
	assign scl_line = ~((scl_oe & ~scl_out) | scl_pull);
	assign sda_line = ~((sda_oe & ~sda_out) | sda_pull);
	software_assisted_twowire_port software_assisted_twowire_port_inst (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl_line),
		.scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
		.bit_count_irq(bit_count_irq), .bus_condition_irq(bus_condition_irq));
	twowire_bus_master m (.hclk(hclk), .scl_line(scl_line), .sda_line(sda_line),
		.scl_pull(scl_pull), .sda_pull(sda_pull));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			fails++;
		end
	endtask
	task automatic addr_phase(input logic [11:0] a, input logic w);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {20'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		hsize  <= 3'b010;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		addr_phase(a, 1'b1);
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask
	// Read data stands in the data phase and is taken at its closing edge
	task automatic rd(input logic [11:0] a, input logic [31:0] msk, input logic [31:0] e);
		addr_phase(a, 1'b0);
		do @(posedge hclk); while (hreadyout !== 1'b1);
		check(hrdata & msk, e);
		@(negedge hclk);
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	// Tests need about 1500 cycles
	initial
	begin
		#300000;
		fails++;
		close_out();
	end
	initial
	begin
		fails = 0;
		n_tests = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h0;
		hwdata = 32'h0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		m.tick(4);
		rd(`DATA_ADDR, 32'hFF, 32'(`DATA_RESET));
		rd(`CTRL_ADDR, 32'h3, 32'(`CTRL_RESET));
		rd(`STAT_ADDR, 32'hF1F, 32'h0);
		check(32'(scl_oe), 32'h0);
		rd(12'h100, 32'hFFFFFFFF, 32'h0);
		// Slave receive, then acknowledge in one-bit mode
		m.start_cond();
		check(32'(bus_condition_irq), 32'h1);
		rd(`STAT_ADDR, CND | STA | STO, CND | STA);
		check(32'(bus_condition_irq), 32'h0);
		wr(`DATA_ADDR, 32'hFF);
		m.byte_xfer(8'hA5, r);
		check(32'(bit_count_irq), 32'h1);
		rd(`STAT_ADDR, 32'hF07, CNT | STR | (32'h8 << `STAT_COUNT_LSB));
		rd(`DATA_ADDR, 32'hFF, 32'hA5);
		rd(`STAT_ADDR, 32'hF07, STR);
		check(32'(scl_oe), 32'h1);
		wr(`CTRL_ADDR, 32'h3);
		wr(`DATA_ADDR, 32'h7F);
		m.tick(2);
		check(32'(scl_oe), 32'h0);
		m.clock_bit(1'b1, b);
		check(32'(b), 32'h0);
		rd(`STAT_ADDR, 32'hF01, CNT | (32'h1 << `STAT_COUNT_LSB));
		m.clock_bit(1'b1, b);
		check(32'(bit_count_irq), 32'h0);
		m.stop_cond();
		rd(`STAT_ADDR, 32'hF12, CND | STO);
		// Slave transmit with a stretched acknowledge clock
		wr(`CTRL_ADDR, 32'h2);
		m.start_cond();
		wr(`DATA_ADDR, 32'h3C);
		m.byte_xfer(8'hFF, r);
		check(32'(r), 32'h3C);
		check(32'(bit_count_irq), 32'h1);
		fork
			m.clock_bit(1'b0, b);
			begin
				m.tick(60);
				check(32'(scl_line), 32'h0);
				wr(`DATA_ADDR, 32'hFF);
			end
		join
		check(32'(bit_count_irq), 32'h0);
		rd(`DATA_ADDR, 32'h1, 32'h0);
		m.stop_cond();
		rd(`STAT_ADDR, CND | STA | STO, CND | STO);
		// Disabled port ignores the pins and leaves SDA released
		wr(`CTRL_ADDR, 32'h0);
		wr(`DATA_ADDR, 32'h0);
		m.tick(2);
		check(32'(sda_oe), 32'h0);
		m.start_cond();
		check(32'(bus_condition_irq), 32'h0);
		close_out();
	end
endmodule
